// [rtl/pcsreg_regs.vh]
/*
 * Register map, field positions, reset values and write masks of the
 * PCS control and status register bank.
 * Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
`ifndef PCSREG_REGS_VH
`define PCSREG_REGS_VH

// Register indices (byte address is four times the index)
`define PCSREG_IDX_ALIGN       10'h10a
`define PCSREG_IDX_BYPASS      10'h101
`define PCSREG_IDX_STATUS      10'h109
`define PCSREG_IDX_SRESET      10'h10b
`define PCSREG_IDX_CFGSRC      10'h100
`define PCSREG_IDX_IRQ_STAT    10'h120
`define PCSREG_IDX_IRQ_MASK    10'h121

// Reset values
`define PCSREG_BYPASS_RST      16'h4230
`define PCSREG_ALIGN_RST       16'h8000
`define PCSREG_SRESET_RST      16'h0000

// Writable bit masks
`define PCSREG_BYPASS_WMASK    16'h4bfc
`define PCSREG_ALIGN_WMASK     16'h9300
`define PCSREG_SRESET_WMASK    16'h00e0

// Bypass register fields
`define PCSREG_B_STAGE         14
`define PCSREG_B_ENC           11
`define PCSREG_B_TXGEAR        9
`define PCSREG_B_LOOP          8
`define PCSREG_B_LSMDIS        7
`define PCSREG_B_SIGDET        6
`define PCSREG_B_RXGEAR        5
`define PCSREG_B_CTC           4
`define PCSREG_B_DEC           3
`define PCSREG_B_WA            2

// Alignment register fields
`define PCSREG_A_LSM           15
`define PCSREG_A_SLIP          12
`define PCSREG_A_FC            9
`define PCSREG_A_ALT           8

// Soft reset fields
`define PCSREG_R_ALL           7
`define PCSREG_R_RX            6
`define PCSREG_R_TX            5

// Interrupt event bits
`define PCSREG_IRQ_W           5
`define PCSREG_I_UNDER         0
`define PCSREG_I_OVER          1
`define PCSREG_I_RXFIFO        2
`define PCSREG_I_TXFIFO        3
`define PCSREG_I_SYNC          4

`endif

// [rtl/pcsreg_bank.v]
/*
 * PCS control and status register bank with a classic Wishbone slave.
 * Assumes the PCS datapath on the same clock drives the status inputs;
 * line synchronisation comes from another domain and is resynchronised.
 * Assumes a master that holds each request until it sees ack or err, and
 * software that leaves the link-keeping skip bits at their reset values.
 * Byte lanes 2 and 3 are ignored; every register fits in the low 16 bits.
 */
// How it works
// - Stage, Tx gearbox and Rx gearbox skip bits reset to one; keep them set.
// - Encoder skip bit 11 resets to zero; when set removes the encoder.
// - Decoder and word aligner skip bits 3 and 2 reset to zero.
// - Compensation skip bit 4 resets to one; clearing inserts compensation FIFO.
// - Loop bit 8 resets zero and loops receive data to transmit cleanly.
// - Signal detect imitation bit 6 resets zero; makes receive see a signal.
// - Status shows FIFO underrun 14, overrun 13, Rx error 12, Tx error 11.
// - Status shows aligner shift 10:7, sync 6, Rx and Tx reset pulses.
// - Status shows inserted 1, deleted 0 flags with inverses at 3 and 2.
// - Alignment enable bit 15 resets one and forces code-group alignment.
// - Word alignment mode bit 12 resets zero; one selects single slip.
// - Fibre channel bit 9 and alternative bit 8 reset zero, pick interpretation.
// - Soft reset register has full reset 7, Rx 6 and Tx 5, reset zero.
// - Source select chooses management ports (0) or the bypass and alignment registers (1).
`timescale 1ns/1ps
`include "pcsreg_regs.vh"

module pcsreg_bank (
   // Clock, reset, enable
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   // Wishbone slave
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [11:0] adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   output reg         err_o,
   // Management port configuration
   input  wire [15:0] mgmt_bypass_i,
   input  wire [15:0] mgmt_align_i,
   // Datapath status
   input  wire        comp_fifo_empty_fault_i,
   input  wire        comp_fifo_full_fault_i,
   input  wire        rx_fifo_error_i,
   input  wire        tx_fifo_error_i,
   input  wire [3:0]  align_shift_i,
   input  wire        line_synchronised_i,
   input  wire        rx_reset_pulse_i,
   input  wire        tx_reset_pulse_i,
   input  wire        char_inserted_flag_i,
   input  wire        char_deleted_flag_i,
   // Datapath controls
   output reg         stage_skip_keep_set_o,
   output reg         encoder_skip_o,
   output reg         tx_gearbox_skip_o,
   output reg         receive_to_transmit_loop_o,
   output reg         line_state_disable_o,
   output reg         signal_detect_force_o,
   output reg         rx_gearbox_skip_o,
   output reg         comp_skip_o,
   output reg         decoder_skip_o,
   output reg         word_aligner_skip_o,
   output reg         code_group_align_o,
   output reg         single_slip_select_o,
   output reg         fibre_channel_interpretation_o,
   output reg         alt_data_interpretation_o,
   output reg         pcs_rx_reset_o,
   output reg         pcs_tx_reset_o,
   // Interrupt
   output reg         irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   // Merge write data into a 16-bit register under byte lanes and a mask
   function [15:0] merge16;
      input [15:0] old;
      input [15:0] wdat;
      input [1:0]  lanes;
      input [15:0] wmask;
      reg   [15:0] lm;
      begin
         lm = {{8{lanes[1]}}, {8{lanes[0]}}} & wmask;
         merge16 = (old & ~lm) | (wdat & lm);
      end
   endfunction

   // Strobe for one register: a taken write at that index with a live lane
   function wr_hit;
      input       wr_now;
      input [9:0] at;
      input [9:0] want;
      input       lane;
      begin
         wr_hit = wr_now & (at == want) & lane;
      end
   endfunction

   // A section is held in reset by its own bit or by the full reset bit
   function section_reset;
      input [15:0] rst_bits;
      input        own_bit;
      begin
         section_reset = rst_bits[`PCSREG_R_ALL] | own_bit;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Registers and decode

   reg  [15:0] bypass_q;
   reg  [15:0] align_q;
   reg  [15:0] sreset_q;
   reg         cfg_src_q;
   reg  [`PCSREG_IRQ_W-1:0] irq_stat_q;
   reg  [`PCSREG_IRQ_W-1:0] irq_mask_q;
   reg         sync_meta_q;
   reg         sync_q;
   reg         sync_prev_q;
   reg  [15:0] status_q;
   reg  [15:0] eff_bypass_d;
   reg  [15:0] eff_align_d;
   reg  [31:0] rdata_d;
   reg         hit_d;
   wire        req;
   wire        wr;
   wire [9:0]  idx;
   wire [`PCSREG_IRQ_W-1:0] events;
   // Per-register write strobes and next interrupt state
   wire        sync_rise;
   wire        wr_bypass;
   wire        wr_align;
   wire        wr_sreset;
   wire        wr_cfgsrc;
   wire        wr_irq_stat;
   wire        wr_irq_mask;
   reg  [`PCSREG_IRQ_W-1:0] irq_stat_d;
   reg  [`PCSREG_IRQ_W-1:0] irq_mask_d;

   // New request only while no ack is out, so each access answers once
   assign req = cyc_i & stb_i & ~ack_o & ~err_o;
   assign wr  = req & we_i & hit_d;
   assign idx = adr_i[11:2];

   // One write strobe per register; the source select and interrupt registers need lane 0
   assign wr_bypass   = wr_hit(wr, idx, `PCSREG_IDX_BYPASS, 1'b1);
   assign wr_align    = wr_hit(wr, idx, `PCSREG_IDX_ALIGN, 1'b1);
   assign wr_sreset   = wr_hit(wr, idx, `PCSREG_IDX_SRESET, 1'b1);
   assign wr_cfgsrc   = wr_hit(wr, idx, `PCSREG_IDX_CFGSRC, sel_i[0]);
   assign wr_irq_stat = wr_hit(wr, idx, `PCSREG_IDX_IRQ_STAT, sel_i[0]);
   assign wr_irq_mask = wr_hit(wr, idx, `PCSREG_IDX_IRQ_MASK, sel_i[0]);

   ////////////////////////////////////////////////////////////////////////////
   // Line sync crosses domains: two flops before any reader
   // The first flop may go metastable; only the second one is read, by the
   // status snapshot and by the sync edge detector

   always @(posedge clk_i) begin
      if (rst_i) begin
         sync_meta_q <= 1'b0;
         sync_q      <= 1'b0;
      end else if (ce_i) begin
         sync_meta_q <= line_synchronised_i;
         sync_q      <= sync_meta_q;
      end
   end

   // Status snapshot; inverses come from the same sampled flags
   // One cycle of latency for the levels, three for line sync; software sees
   // a recent sample, never the value of this very cycle
   always @(posedge clk_i) begin
      if (rst_i) begin
         status_q <= 16'h000c;
      end else if (ce_i) begin
         status_q <= {1'b0, comp_fifo_empty_fault_i, comp_fifo_full_fault_i,
                      rx_fifo_error_i, tx_fifo_error_i,
                      align_shift_i, sync_q,
                      rx_reset_pulse_i, tx_reset_pulse_i,
                      ~char_inserted_flag_i, ~char_deleted_flag_i,
                      char_inserted_flag_i, char_deleted_flag_i};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read decode

   // Unmapped indices answer with err and read zero; reserved bits of the
   // mapped registers are already zero in the stored value, since the write
   // masks never let a one into them
   always @* begin
      hit_d   = 1'b1;
      rdata_d = 32'h0000_0000;
      case (idx)
         `PCSREG_IDX_BYPASS:   rdata_d = {16'h0000, bypass_q};
         `PCSREG_IDX_STATUS:   rdata_d = {16'h0000, status_q};
         `PCSREG_IDX_ALIGN:    rdata_d = {16'h0000, align_q};
         `PCSREG_IDX_SRESET:   rdata_d = {16'h0000, sreset_q};
         `PCSREG_IDX_CFGSRC:   rdata_d = {31'h0, cfg_src_q};
         `PCSREG_IDX_IRQ_STAT: rdata_d = {27'h0, irq_stat_q};
         `PCSREG_IDX_IRQ_MASK: rdata_d = {27'h0, irq_mask_q};
         default:              hit_d   = 1'b0;
      endcase
   end

   // One-wait answer: ack or err one edge after the request is seen
   // A write lands at the taking edge, so a read right behind it sees it
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_o <= req & hit_d;
         err_o <= req & ~hit_d;
         dat_o <= (req & hit_d & ~we_i) ? rdata_d : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers; masks keep reserved bits at zero

   // Bypass register: the link-keeping skip bits come out of reset set
   always @(posedge clk_i) begin
      if (rst_i) begin
         bypass_q <= `PCSREG_BYPASS_RST;
      end else if (ce_i && wr_bypass) begin
         bypass_q <= merge16(bypass_q, dat_i[15:0], sel_i[1:0],
                             `PCSREG_BYPASS_WMASK);
      end
   end

   // Alignment register: code-group alignment enabled out of reset
   always @(posedge clk_i) begin
      if (rst_i) begin
         align_q <= `PCSREG_ALIGN_RST;
      end else if (ce_i && wr_align) begin
         align_q <= merge16(align_q, dat_i[15:0], sel_i[1:0],
                            `PCSREG_ALIGN_WMASK);
      end
   end

   // Soft reset register: both sections run out of reset
   always @(posedge clk_i) begin
      if (rst_i) begin
         sreset_q <= `PCSREG_SRESET_RST;
      end else if (ce_i && wr_sreset) begin
         sreset_q <= merge16(sreset_q, dat_i[15:0], sel_i[1:0],
                             `PCSREG_SRESET_WMASK);
      end
   end

   // Source select: management ports until software claims the controls
   always @(posedge clk_i) begin
      if (rst_i) begin
         cfg_src_q <= 1'b0;
      end else if (ce_i && wr_cfgsrc) begin
         cfg_src_q <= dat_i[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status: sticky, write one to clear, set beats clear

   // Only the rising edge of line sync is an event; the FIFO faults are levels
   // and keep their bit set for as long as they last
   assign sync_rise = sync_q & ~sync_prev_q;
   assign events    = {sync_rise, tx_fifo_error_i, rx_fifo_error_i,
                       comp_fifo_full_fault_i, comp_fifo_empty_fault_i};

   // Next status and mask; events are or-ed in after the clear so that an
   // event in the same cycle as its clear still lands
   always @* begin
      irq_stat_d = irq_stat_q;
      irq_mask_d = irq_mask_q;
      if (wr_irq_stat)
         irq_stat_d = irq_stat_q & ~dat_i[`PCSREG_IRQ_W-1:0];
      irq_stat_d = irq_stat_d | events;
      if (wr_irq_mask)
         irq_mask_d = dat_i[`PCSREG_IRQ_W-1:0];
   end

   // The level is taken from the next state, so a clear or a mask write
   // drops it at once instead of one cycle late
   always @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q  <= {`PCSREG_IRQ_W{1'b0}};
         irq_mask_q  <= {`PCSREG_IRQ_W{1'b0}};
         sync_prev_q <= 1'b0;
         irq_o       <= 1'b0;
      end else if (ce_i) begin
         sync_prev_q <= sync_q;
         irq_stat_q  <= irq_stat_d;
         irq_mask_q  <= irq_mask_d;
         irq_o       <= |(irq_stat_d & irq_mask_d);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Source select between management ports and registers

   // Software owns the bypass and alignment controls only once it sets the source bit; until then
   // the management ports drive them, so early writes to those two registers are harmless
   always @* begin
      eff_bypass_d = cfg_src_q ? bypass_q : mgmt_bypass_i;
      eff_align_d  = cfg_src_q ? align_q  : mgmt_align_i;
   end

   // Drive datapath controls from flops; the loop select changes only here,
   // so the datapath sees one clean edge per change
   always @(posedge clk_i) begin
      if (rst_i) begin
         stage_skip_keep_set_o          <= 1'b1;
         encoder_skip_o                 <= 1'b0;
         tx_gearbox_skip_o              <= 1'b1;
         receive_to_transmit_loop_o     <= 1'b0;
         line_state_disable_o           <= 1'b0;
         signal_detect_force_o          <= 1'b0;
         rx_gearbox_skip_o              <= 1'b1;
         comp_skip_o                    <= 1'b1;
         decoder_skip_o                 <= 1'b0;
         word_aligner_skip_o            <= 1'b0;
      end else if (ce_i) begin
         stage_skip_keep_set_o          <= eff_bypass_d[`PCSREG_B_STAGE];
         encoder_skip_o                 <= eff_bypass_d[`PCSREG_B_ENC];
         tx_gearbox_skip_o              <= eff_bypass_d[`PCSREG_B_TXGEAR];
         receive_to_transmit_loop_o     <= eff_bypass_d[`PCSREG_B_LOOP];
         line_state_disable_o           <= eff_bypass_d[`PCSREG_B_LSMDIS];
         signal_detect_force_o          <= eff_bypass_d[`PCSREG_B_SIGDET];
         rx_gearbox_skip_o              <= eff_bypass_d[`PCSREG_B_RXGEAR];
         comp_skip_o                    <= eff_bypass_d[`PCSREG_B_CTC];
         decoder_skip_o                 <= eff_bypass_d[`PCSREG_B_DEC];
         word_aligner_skip_o            <= eff_bypass_d[`PCSREG_B_WA];
      end
   end

   // Alignment and interpretation modes follow the effective alignment word
   always @(posedge clk_i) begin
      if (rst_i) begin
         code_group_align_o             <= 1'b1;
         single_slip_select_o           <= 1'b0;
         fibre_channel_interpretation_o <= 1'b0;
         alt_data_interpretation_o      <= 1'b0;
      end else if (ce_i) begin
         // Enable forces alignment whatever disable and fibre mode say
         code_group_align_o             <= eff_align_d[`PCSREG_A_LSM] |
                                           (~eff_bypass_d[`PCSREG_B_LSMDIS] &
                                            ~eff_align_d[`PCSREG_A_FC]);
         single_slip_select_o           <= eff_align_d[`PCSREG_A_SLIP];
         fibre_channel_interpretation_o <= eff_align_d[`PCSREG_A_FC];
         alt_data_interpretation_o      <= eff_align_d[`PCSREG_A_ALT];
      end
   end

   // Section resets are levels, held for as long as a bit reads one
   always @(posedge clk_i) begin
      if (rst_i) begin
         pcs_rx_reset_o <= 1'b0;
         pcs_tx_reset_o <= 1'b0;
      end else if (ce_i) begin
         pcs_rx_reset_o <= section_reset(sreset_q, sreset_q[`PCSREG_R_RX]);
         pcs_tx_reset_o <= section_reset(sreset_q, sreset_q[`PCSREG_R_TX]);
      end
   end

endmodule

// [bench/pcsreg_chk.sv]
/*
 * Port checker for the PCS control and status register bank.
 * Assumes it is bound to pcsreg_bank and sees only that module's ports.
 */
`timescale 1ns/1ps
module pcsreg_chk (
   // Clock and control
   input wire        clk_i,
   input wire        rst_i,
   input wire        ce_i,
   // Bus
   input wire        cyc_i,
   input wire        stb_i,
   input wire [31:0] dat_o,
   input wire        ack_o,
   input wire        err_o,
   // Datapath controls
   input wire        stage_skip_keep_set_o,
   input wire        tx_gearbox_skip_o,
   input wire        rx_gearbox_skip_o,
   input wire        comp_skip_o,
   input wire        encoder_skip_o,
   input wire        receive_to_transmit_loop_o,
   input wire        line_state_disable_o,
   input wire        fibre_channel_interpretation_o,
   input wire        code_group_align_o,
   input wire        irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////
   // A request the slave may take, and its single answer
   sequence req_taken_s;
      ce_i && cyc_i && stb_i && !ack_o && !err_o;
   endsequence
   sequence answer_s;
      ack_o ^ err_o;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   req_answer_a: assert property (req_taken_s |=> answer_s)
      else $error("no answer one cycle after a request");
   ack_pulse_a: assert property (answer_s and ce_i |=> !ack_o && !err_o)
      else $error("answer held longer than one cycle");
   ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without a request");
   rdata_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data not zero outside ack");
   err_quiet_a: assert property (err_o |-> !ack_o && dat_o == 32'h0)
      else $error("error answer carries ack or data");
   // Outputs at the first edge after reset still show reset values
   reset_values_a: assert property ($fell(rst_i) |-> stage_skip_keep_set_o &&
      tx_gearbox_skip_o && rx_gearbox_skip_o && comp_skip_o && !encoder_skip_o &&
      !receive_to_transmit_loop_o && code_group_align_o)
      else $error("control outputs not at reset values");
   cg_align_a: assert property (!line_state_disable_o &&
      !fibre_channel_interpretation_o |-> code_group_align_o)
      else $error("code-group alignment off with both disables clear");
   ce_freeze_a: assert property (!ce_i |=> $stable(irq_o) &&
      $stable(receive_to_transmit_loop_o))
      else $error("state moved while clock enable low");
endmodule
bind pcsreg_bank pcsreg_chk chk (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .dat_o, .ack_o,
   .err_o, .stage_skip_keep_set_o, .tx_gearbox_skip_o, .rx_gearbox_skip_o, .comp_skip_o,
   .encoder_skip_o, .receive_to_transmit_loop_o, .line_state_disable_o,
   .fibre_channel_interpretation_o, .code_group_align_o, .irq_o);

// [bench/pcs_control_status_regs_tb.sv]
/*
 * Self-checking bench for the PCS control and status register bank.
 * Assumes pcsreg_regs.vh on the include path and the port checker bound.
 */
`timescale 1ns/1ps
`include "pcsreg_regs.vh"
module pcs_control_status_regs_tb;
   reg         clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   reg  [11:0] adr_i = 12'h0;
   reg  [3:0]  sel_i = 4'h0;
   reg  [31:0] dat_i = 32'h0;
   reg  [15:0] mgmt_bypass_i = 16'h0, mgmt_align_i = 16'h0;
   reg  [12:0] stv = 13'h0;
   wire [31:0] dat_o;
   wire        ack_o, err_o, stage_skip_keep_set_o, encoder_skip_o, tx_gearbox_skip_o;
   wire        receive_to_transmit_loop_o, line_state_disable_o, signal_detect_force_o;
   wire        rx_gearbox_skip_o, comp_skip_o, decoder_skip_o, word_aligner_skip_o;
   wire        code_group_align_o, single_slip_select_o, fibre_channel_interpretation_o;
   wire        alt_data_interpretation_o, pcs_rx_reset_o, pcs_tx_reset_o, irq_o;
   integer     bad_count = 0, checked = 0, cycles = 0, i, k;
   reg  [31:0] r, d;
   reg  [3:0]  s;
   reg         e;
   reg  [15:0] sh [0:2];
   reg  [9:0]  ix [0:2];
   reg  [15:0] wm [0:2];
   // Controls packed back into their register layouts
   wire [15:0] byp_seen = {1'b0, stage_skip_keep_set_o, 2'b00, encoder_skip_o, 1'b0,
      tx_gearbox_skip_o, receive_to_transmit_loop_o, line_state_disable_o,
      signal_detect_force_o, rx_gearbox_skip_o, comp_skip_o, decoder_skip_o,
      word_aligner_skip_o, 2'b00};
   wire [15:0] aln_seen = {3'b000, single_slip_select_o, 2'b00,
      fibre_channel_interpretation_o, alt_data_interpretation_o, 8'h00};
   ////////////////////////////////////////////////////////////////////////
   pcsreg_bank dut (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
      .dat_o, .ack_o, .err_o, .mgmt_bypass_i, .mgmt_align_i,
      .comp_fifo_empty_fault_i(stv[12]), .comp_fifo_full_fault_i(stv[11]),
      .rx_fifo_error_i(stv[10]), .tx_fifo_error_i(stv[9]), .align_shift_i(stv[8:5]),
      .line_synchronised_i(stv[4]), .rx_reset_pulse_i(stv[3]), .tx_reset_pulse_i(stv[2]),
      .char_inserted_flag_i(stv[1]), .char_deleted_flag_i(stv[0]),
      .stage_skip_keep_set_o, .encoder_skip_o, .tx_gearbox_skip_o,
      .receive_to_transmit_loop_o, .line_state_disable_o, .signal_detect_force_o,
      .rx_gearbox_skip_o, .comp_skip_o, .decoder_skip_o, .word_aligner_skip_o,
      .code_group_align_o, .single_slip_select_o, .fibre_channel_interpretation_o,
      .alt_data_interpretation_o, .pcs_rx_reset_o, .pcs_tx_reset_o, .irq_o);
   ////////////////////////////////////////////////////////////////////////
   // 25 MHz clock and a hang limit well above the expected run
   always #20 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         bad_count = bad_count + 1;
         final_report;
      end
   end
   // Only enabled lanes reach writable bits
   function [15:0] merge(input [15:0] old, input [15:0] w, input [3:0] sl, input [15:0] m);
      reg [15:0] lm;
      begin
         lm = {{8{sl[1]}}, {8{sl[0]}}} & m;
         merge = (old & ~lm) | (w & lm);
      end
   endfunction
   task chk(input [32:0] seen, input [32:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
         end
      end
   endtask
   // Classic cycle: hold everything until ack or err is seen at an edge
   task wb(input w, input [9:0] idx, input [31:0] wd, input [3:0] sl);
      integer n;
      begin
         n = 0;
         @(posedge clk_i);
         {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, idx, 2'b00, sl, wd};
         @(posedge clk_i);
         while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n = n + 1;
         end
         chk(n < 50, 1'b1);
         r = dat_o;
         e = err_o;
         {cyc_i, stb_i} <= 2'b00;
      end
   endtask
   task rd(input [9:0] idx, input [31:0] exp);
      begin
         wb(1'b0, idx, 32'h0, 4'hf);
         chk({e, r}, {1'b0, exp});
      end
   endtask
   task final_report;
      begin
         $display("comparisons %0d, mismatches %0d", checked, bad_count);
         if (bad_count == 0 && checked > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(40250));
      {ix[0], ix[1], ix[2]} = {`PCSREG_IDX_BYPASS, `PCSREG_IDX_ALIGN, `PCSREG_IDX_SRESET};
      {wm[0], wm[1], wm[2]} = {16'h4bfc, 16'h9300, 16'h00e0};
      {sh[0], sh[1], sh[2]} = {16'h4230, 16'h8000, 16'h0000};
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`PCSREG_IDX_BYPASS, 32'h4230);
      rd(`PCSREG_IDX_ALIGN, 32'h8000);
      rd(`PCSREG_IDX_SRESET, 32'h0);
      rd(`PCSREG_IDX_STATUS, 32'h000c);
      rd(`PCSREG_IDX_CFGSRC, 32'h0);
      rd(`PCSREG_IDX_IRQ_MASK, 32'h0);
      // Management ports drive the controls while the source bit is clear
      {mgmt_bypass_i, mgmt_align_i} <= $urandom;
      repeat (3) @(posedge clk_i);
      chk({byp_seen, aln_seen}, {mgmt_bypass_i & 16'h4bfc, mgmt_align_i & 16'h1300});
      wb(1'b1, `PCSREG_IDX_CFGSRC, 32'h1, 4'h1);
      wb(1'b1, 10'h3ff, 32'hffff, 4'hf);
      chk(e, 1'b1);
      // Random and all-ones writes, read back and seen on the controls
      for (i = 0; i < 40; i = i + 1) begin
         k = $urandom % 3;
         d = (i < 4) ? {32{i[0]}} : $urandom;
         s = (i < 4) ? 4'hf : d[23:20];
         sh[k] = merge(sh[k], d[15:0], s, wm[k]);
         wb(1'b1, ix[k], d, s);
         rd(ix[k], {16'h0, sh[k]});
         chk(byp_seen, sh[0]);
         chk(aln_seen, sh[1] & 16'h1300);
         chk(code_group_align_o, {sh[1][15] | (~sh[0][7] & ~sh[1][9])});
         chk({pcs_rx_reset_o, pcs_tx_reset_o}, {|sh[2][7:6], sh[2][7] | sh[2][5]});
      end
      // Loop set and left standing over 500 ns before any frame could start
      wb(1'b1, `PCSREG_IDX_BYPASS, 32'h4330, 4'h3);
      repeat (13) @(posedge clk_i);
      chk(receive_to_transmit_loop_o, 1'b1);
      // Software keeps alignment enabled with the prescribed word
      wb(1'b1, `PCSREG_IDX_ALIGN, 32'h8000, 4'h3);
      rd(`PCSREG_IDX_ALIGN, 32'h8000);
      chk(code_group_align_o, 1'b1);
      // Status inputs appear in the status register; writes there do nothing
      for (i = 0; i < 8; i = i + 1) begin
         d = $urandom;
         stv <= (i == 0) ? 13'h1fff : d[12:0];
         wb(1'b1, `PCSREG_IDX_STATUS, 32'hffff, 4'hf);
         repeat (4) @(posedge clk_i);
         rd(`PCSREG_IDX_STATUS, {17'h0, stv[12:2], ~stv[1:0], stv[1:0]});
      end
      stv <= 13'h0;
      ce_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      ce_i <= 1'b1;
      // Interrupt: clear, raise an Rx FIFO error, mask it, clear it
      wb(1'b1, `PCSREG_IDX_IRQ_MASK, 32'h1f, 4'hf);
      wb(1'b1, `PCSREG_IDX_IRQ_STAT, 32'h1f, 4'hf);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b0);
      stv <= 13'h0400;
      @(posedge clk_i);
      stv <= 13'h0;
      repeat (3) @(posedge clk_i);
      chk(irq_o, 1'b1);
      rd(`PCSREG_IDX_IRQ_STAT, 32'h4);
      wb(1'b1, `PCSREG_IDX_IRQ_MASK, 32'h0, 4'hf);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b0);
      wb(1'b1, `PCSREG_IDX_IRQ_MASK, 32'h1f, 4'hf);
      wb(1'b1, `PCSREG_IDX_IRQ_STAT, 32'h4, 4'hf);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b0);
      rd(`PCSREG_IDX_IRQ_STAT, 32'h0);
      final_report;
   end
endmodule
